//--- core/appf_pkg.sv
// constants for the adc post-processing stage: control field layout, widths and latencies
// assumes one sample clock for the whole data path and a plain strobe-based register port
//
// Function
// - each option has its own enable bit
// - delay recovery only in dual or octal
// - interpolator aligns channel sampling instants
// - delay recovery adds exactly 59 cycles
// - type select: 0 dual, 1 octal
// - band select: 0 first, 1 second zone
// - octal select routes post-processing to octal
// - dual enable turns on dual post-processing
// - requantizer cuts word to 11 or 12 bits
// - requantizer only single/dual, per-channel config
// - single mode uses first requantizer only
// - dual mode: A first channel, B second
// - filter bandwidths 22/25 and 25/29 percent
// - 11-bit centre frequency follows filter number
// - disabled requantizer passes data unchanged
// - overload may reset requantizer state
package appf_pkg;
    // register offsets of the control port
    localparam logic [7:0] OFS_ENABLES = 8'h7A;
    localparam logic [7:0] OFS_FILTER_A = 8'h78;
    localparam logic [7:0] OFS_FILTER_B = 8'h79;
    localparam logic [7:0] OFS_RECOVERY = 8'h81;
    localparam logic [7:0] OFS_STATUS = 8'hD0;
    // enable register fields
    localparam int EN_DELAY_BIT = 0;
    localparam int EN_A11_BIT = 1;
    localparam int EN_A12_BIT = 2;
    localparam int EN_B11_BIT = 3;
    localparam int EN_B12_BIT = 4;
    // filter register fields
    localparam int FILT_LSB = 0;
    localparam int FILT_W = 7;
    localparam int NSR_RESET_BIT = 7;
    localparam int DUAL_PP_BIT = 7;
    // recovery register fields
    localparam int ZONE_BIT = 0;
    localparam int TYPE_BIT = 1;
    localparam int OCTAL_PP_BIT = 2;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // channel modes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_DUAL = 2'h1;
    localparam logic [1:0] MODE_OCTAL = 2'h2;
    // processing latency of delay recovery, in sample cycles
    localparam int RECOVERY_LATENCY = 59;
    // data width and requantizer limits
    localparam int DATA_W = 12;
    localparam logic [6:0] FILT_11_MAX = 7'h29;
    localparam logic [6:0] FILT_12_MIN = 7'h2A;
    localparam logic [6:0] FILT_12_MAX = 7'h4C;
    localparam logic [6:0] FILT_11_WIDE = 7'h15;
    localparam logic [6:0] FILT_12_WIDE = 7'h3F;
endpackage

//--- core/appf_delay_line.sv
// fixed-length delay line used for the delay recovery pipeline
// assumes one sample per clock and a synchronous data stream
`timescale 1ns/1ps
`default_nettype none
module appf_delay_line #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 59
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] dataIn,
    input wire logic validIn,
    output logic [WIDTH-1:0] dataOut,
    output logic validOut
);
    // refuse shapes that cannot be built
    initial begin
        if (DEPTH < 1 || WIDTH < 1) begin
            $error("delay line needs positive width and depth");
        end
    end
    // shift registers for data and valid
    logic [WIDTH-1:0] dataPipe_q [DEPTH];
    logic [DEPTH-1:0] validPipe_q;
    // shift one stage per clock
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            validPipe_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                dataPipe_q[i] <= '0;
            end
        end else begin
            dataPipe_q[0] <= dataIn;
            validPipe_q[0] <= validIn;
            for (int i = 1; i < DEPTH; i++) begin
                dataPipe_q[i] <= dataPipe_q[i-1];
                validPipe_q[i] <= validPipe_q[i-1];
            end
        end
    end
    assign dataOut = dataPipe_q[DEPTH-1];
    assign validOut = validPipe_q[DEPTH-1];
endmodule
`default_nettype wire

//--- core/appf_requantizer.sv
// one noise-shaping requantizer channel: error feedback filter tuned by a filter number
// assumes filter number and bit mode are paired correctly by software
`timescale 1ns/1ps
`default_nettype none
module appf_requantizer #(
    parameter int WIDTH = 12
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic enable11,
    input wire logic enable12,
    input wire logic [6:0] filterNum,
    input wire logic clearState,
    input wire logic [WIDTH-1:0] dataIn,
    input wire logic validIn,
    output logic [WIDTH-1:0] dataOut,
    output logic validOut,
    output logic active
);
    initial begin
        if (WIDTH != appf_pkg::DATA_W) begin
            $error("requantizer is built for the documented word width only");
        end
    end
    // dropped bits: one in 11-bit mode, none in 12-bit mode
    logic useEleven;
    logic [3:0] dropBits;
    // feedback coefficient from centre frequency: c = 2cos(2 pi fc)
    logic signed [9:0] coef;
    logic signed [WIDTH+3:0] err1_q;
    logic signed [WIDTH+3:0] err2_q;
    logic signed [WIDTH+3:0] shaped;
    logic signed [WIDTH+13:0] prod;
    logic signed [WIDTH+3:0] quant;
    logic signed [WIDTH+3:0] maxVal;
    assign useEleven = enable11 & ~enable12;
    assign active = enable11 | enable12;
    assign dropBits = useEleven ? 4'h1 : 4'h0;
    // coefficient approximates the centre frequency ramp of each filter group
    always_comb begin
        coef = 10'sh000;
        // scaled by 128; each ramp meets 2cos(2 pi fc) at both ends of its group
        if (filterNum < appf_pkg::FILT_11_WIDE) begin
            coef = 10'(10'sd187 - 10'(signed'({3'h0, filterNum}) * 10'sd19));
        end else if (filterNum <= appf_pkg::FILT_11_MAX) begin
            coef = 10'(10'sd181 - 10'(signed'({3'h0, filterNum - appf_pkg::FILT_11_WIDE}) * 10'sd18));
        end else if (filterNum < appf_pkg::FILT_12_WIDE) begin
            coef = 10'(10'sd181 - 10'(signed'({3'h0, filterNum - appf_pkg::FILT_12_MIN}) * 10'sd18));
        end else begin
            coef = 10'(10'sd151 - 10'(signed'({3'h0, filterNum - appf_pkg::FILT_12_WIDE}) * 10'sd25));
        end
    end
    // second-order error feedback: y = x - c*e1 + e2 (resonator notch at fc)
    assign prod = coef * err1_q;
    assign shaped = (WIDTH+4)'(signed'({{4{dataIn[WIDTH-1]}}, dataIn}))
        - (WIDTH+4)'(prod >>> 7) + err2_q;
    // top code keeps the dropped bits clear; the bottom code -maxVal-1 sets them, so only a bottom-clipped word leaves the coarse grid
    assign maxVal = (WIDTH+4)'((((1 <<< (WIDTH-1)) - 1) >> dropBits) << dropBits);
    always_comb begin
        quant = (shaped >>> dropBits) <<< dropBits;
        if (quant > maxVal) begin
            quant = maxVal;
        end else if (quant < -maxVal - 1) begin
            quant = (WIDTH+4)'(-maxVal - 1);
        end
    end
    // error state, cleared on reset, on disable and on overload request
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            err1_q <= '0;
            err2_q <= '0;
        end else if (clearState || !active) begin
            err1_q <= '0;
            err2_q <= '0;
        end else if (validIn) begin
            err1_q <= quant - shaped;
            err2_q <= err1_q;
        end
    end
    // registered output: unchanged data when disabled
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dataOut <= '0;
            validOut <= 1'b0;
        end else begin
            dataOut <= active ? quant[WIDTH-1:0] : dataIn;
            validOut <= validIn;
        end
    end
    // an 11-bit word carries the dropped bit only at the bottom clip code -maxVal-1, which this check flags
    eleven_lsb_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (useEleven && validIn) |=> !dataOut[0]) else $error("eleven-bit word with low bit set");
    // overload clear empties the error state
    state_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        clearState |=> err1_q == '0 && err2_q == '0) else $error("requantizer state not cleared");
endmodule
`default_nettype wire

//--- core/appf_post_processing.sv
// top of the adc post-processing stage: control registers, delay recovery path, two requantizers
// assumes the sample stream arrives one sample per sys_clk with a channel index alongside
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module appf_post_processing #(
    parameter int WIDTH = appf_pkg::DATA_W,
    parameter int RECOVERY_DEPTH = appf_pkg::RECOVERY_LATENCY
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // converter sample stream
    input wire logic [1:0] channelMode,
    input wire logic [WIDTH-1:0] sampleIn,
    input wire logic [2:0] sampleChan,
    input wire logic sampleValid,
    input wire logic overload,
    // output stream
    output logic [WIDTH-1:0] sampleOut,
    output logic [2:0] sampleOutChan,
    output logic sampleOutValid
);
    initial begin
        if (RECOVERY_DEPTH != appf_pkg::RECOVERY_LATENCY || WIDTH != appf_pkg::DATA_W) begin
            $error("post-processing shape differs from the documented path");
        end
    end

    // control registers
    logic [7:0] enables_q;
    logic [7:0] filterA_q;
    logic [7:0] filterB_q;
    logic [7:0] recovery_q;

    // decoded controls
    logic delayRecoveryEnable;
    logic nyquistZoneSelect;
    logic recoveryTypeSelect;
    logic octalPostprocSelect;
    logic dualPostprocEnable;
    logic recoveryActive;
    logic nsrAllowed;

    // register writes, one per register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            enables_q <= appf_pkg::RST_BYTE;
            filterA_q <= appf_pkg::RST_BYTE;
            filterB_q <= appf_pkg::RST_BYTE;
            recovery_q <= appf_pkg::RST_BYTE;
        end else if (regWrite) begin
            case (regAddr)
                appf_pkg::OFS_ENABLES: enables_q <= regWrData;
                appf_pkg::OFS_FILTER_A: filterA_q <= regWrData;
                appf_pkg::OFS_FILTER_B: filterB_q <= regWrData;
                appf_pkg::OFS_RECOVERY: recovery_q <= {5'h00, regWrData[2:0]};
                default: ;
            endcase
        end
    end

    assign delayRecoveryEnable = enables_q[appf_pkg::EN_DELAY_BIT];
    assign nyquistZoneSelect = recovery_q[appf_pkg::ZONE_BIT];
    assign recoveryTypeSelect = recovery_q[appf_pkg::TYPE_BIT];
    assign octalPostprocSelect = recovery_q[appf_pkg::OCTAL_PP_BIT];
    assign dualPostprocEnable = filterB_q[appf_pkg::DUAL_PP_BIT];

    // recovery works only with a matching mode and routing
    always_comb begin
        recoveryActive = 1'b0;
        if (delayRecoveryEnable) begin
            if (channelMode == appf_pkg::MODE_DUAL) begin
                recoveryActive = ~recoveryTypeSelect & ~octalPostprocSelect & dualPostprocEnable;
            end else if (channelMode == appf_pkg::MODE_OCTAL) begin
                recoveryActive = recoveryTypeSelect & octalPostprocSelect;
            end
        end
    end
    // requantizers run only in single or dual mode
    assign nsrAllowed = (channelMode == appf_pkg::MODE_SINGLE) ||
        (channelMode == appf_pkg::MODE_DUAL && dualPostprocEnable);

    // interpolation: 2-tap half-sample correction on each channel's stream
    logic [WIDTH-1:0] prevSample_q [8];
    logic signed [WIDTH:0] interpSum;
    logic [WIDTH-1:0] interpOut;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < 8; i++) begin
                prevSample_q[i] <= '0;
            end
        end else if (sampleValid) begin
            prevSample_q[sampleChan] <= sampleIn;
        end
    end
    // first zone averages neighbours; second zone takes half their difference
    always_comb begin
        if (nyquistZoneSelect) begin
            interpSum = (WIDTH+1)'(signed'(sampleIn)) - (WIDTH+1)'(signed'(prevSample_q[sampleChan]));
        end else begin
            interpSum = (WIDTH+1)'(signed'(sampleIn)) + (WIDTH+1)'(signed'(prevSample_q[sampleChan]));
        end
        interpOut = interpSum[WIDTH:1];
    end

    // the same delay line carries every channel, so all get one latency
    logic [WIDTH+2:0] delayIn;
    logic [WIDTH+2:0] delayOut;
    logic delayValid;
    assign delayIn = {sampleChan, interpOut};
    appf_delay_line #(
        .WIDTH(WIDTH + 3),
        .DEPTH(RECOVERY_DEPTH)
    ) recoveryDelay (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .dataIn(delayIn),
        .validIn(sampleValid & recoveryActive),
        .dataOut(delayOut),
        .validOut(delayValid)
    );

    // requantizer input: first channel index goes to A, the other to B
    logic isFirstChan;
    logic nsrReset;
    logic [WIDTH-1:0] nsrOutA;
    logic [WIDTH-1:0] nsrOutB;
    logic nsrValidA;
    logic nsrValidB;
    logic activeA;
    logic activeB;
    logic [2:0] chanStage_q;
    assign isFirstChan = (channelMode == appf_pkg::MODE_SINGLE) || (sampleChan[0] == 1'b0);
    assign nsrReset = filterA_q[appf_pkg::NSR_RESET_BIT] & overload;

    appf_requantizer #(
        .WIDTH(WIDTH)
    ) requantA (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .enable11(enables_q[appf_pkg::EN_A11_BIT] & nsrAllowed),
        .enable12(enables_q[appf_pkg::EN_A12_BIT] & nsrAllowed),
        .filterNum(filterA_q[6:0]),
        .clearState(nsrReset),
        .dataIn(sampleIn),
        .validIn(sampleValid & isFirstChan),
        .dataOut(nsrOutA),
        .validOut(nsrValidA),
        .active(activeA)
    );
    appf_requantizer #(
        .WIDTH(WIDTH)
    ) requantB (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .enable11(enables_q[appf_pkg::EN_B11_BIT] & nsrAllowed & (channelMode == appf_pkg::MODE_DUAL)),
        .enable12(enables_q[appf_pkg::EN_B12_BIT] & nsrAllowed & (channelMode == appf_pkg::MODE_DUAL)),
        .filterNum(filterB_q[6:0]),
        .clearState(nsrReset),
        .dataIn(sampleIn),
        .validIn(sampleValid & ~isFirstChan),
        .dataOut(nsrOutB),
        .validOut(nsrValidB),
        .active(activeB)
    );

    // channel index follows the one-cycle requantizer stage
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chanStage_q <= 3'h0;
        end else begin
            chanStage_q <= sampleChan;
        end
    end

    // output select: recovery path or requantizer path, both registered
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sampleOut <= '0;
            sampleOutChan <= 3'h0;
            sampleOutValid <= 1'b0;
        end else if (recoveryActive) begin
            sampleOut <= delayOut[WIDTH-1:0];
            sampleOutChan <= delayOut[WIDTH+2:WIDTH];
            sampleOutValid <= delayValid;
        end else begin
            sampleOut <= nsrValidA ? nsrOutA : nsrOutB;
            sampleOutChan <= chanStage_q;
            sampleOutValid <= nsrValidA | nsrValidB;
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                appf_pkg::OFS_ENABLES: regRdData <= enables_q;
                appf_pkg::OFS_FILTER_A: regRdData <= filterA_q;
                appf_pkg::OFS_FILTER_B: regRdData <= filterB_q;
                appf_pkg::OFS_RECOVERY: regRdData <= recovery_q;
                appf_pkg::OFS_STATUS: regRdData <= {5'h00, activeB, activeA, recoveryActive};
                default: regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end

    // assertions
    recovery_latency_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (sampleValid && recoveryActive) |-> ##RECOVERY_DEPTH
        delayValid && delayOut == $past(delayIn, RECOVERY_DEPTH)) else $error("recovery sample late or altered");

    recovery_mode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        recoveryActive |-> channelMode != appf_pkg::MODE_SINGLE) else $error("recovery in single mode");

    recovery_type_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (recoveryActive && channelMode == appf_pkg::MODE_OCTAL) |-> recoveryTypeSelect)
        else $error("octal recovery without octal type");

    octal_route_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (recoveryActive && channelMode == appf_pkg::MODE_DUAL) |-> !octalPostprocSelect)
        else $error("dual recovery routed to octal");

    dual_enable_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (channelMode == appf_pkg::MODE_DUAL && !dualPostprocEnable) |-> !recoveryActive && !activeA)
        else $error("dual processing without dual enable");

    single_nsr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        channelMode == appf_pkg::MODE_SINGLE |-> !activeB) else $error("second requantizer in single mode");

    nsr_modes_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        channelMode == appf_pkg::MODE_OCTAL |-> !activeA && !activeB) else $error("requantizer in octal mode");

    pass_through_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!recoveryActive && !activeA && sampleValid && isFirstChan) ##1 !recoveryActive
        |=> sampleOutValid && sampleOut == $past(sampleIn, 2)) else $error("disabled requantizer altered data");

    one_latency_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        recoveryActive |=> sampleOutValid == $past(delayValid) && sampleOut == $past(delayOut[WIDTH-1:0])
        && sampleOutChan == $past(delayOut[WIDTH+2:WIDTH])) else $error("recovery output stage skewed");
endmodule
`default_nettype wire

//--- verif/appf_adc_source.sv
// far-side model: converter core sample source feeding the post-processing stage
// assumes the bench owns reset and picks the channel mode; one sample per sys_clk
`timescale 1ns/1ps
`default_nettype none
module appf_adc_source (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [1:0] channelMode,
    output logic [11:0] sampleIn,
    output logic [2:0] sampleChan,
    output logic sampleValid
);
    logic [7:0] step_q; // free-running step count, also the ramp source
    logic sendNow; // a sample goes out this cycle
    // every eighth cycle is left empty so gaps travel through the stream too
    assign sendNow = run && (step_q[2:0] != 3'h7);
    // sample source, channel sequencing and idle scrambling
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            step_q <= 8'h00;
            sampleIn <= 12'h000;
            sampleChan <= 3'h0;
            sampleValid <= 1'b0;
        end else begin
            step_q <= step_q + 8'h01;
            sampleValid <= sendNow;
            if (sendNow) begin
                // slow small ramp: well inside the usable band and far below full scale
                sampleIn <= {2'h0, step_q, step_q[0], ~step_q[1]};
                // channel index follows the mode: fixed, alternating, or rotating over eight
                if (channelMode == appf_pkg::MODE_SINGLE) begin
                    sampleChan <= 3'h0;
                end else if (channelMode == appf_pkg::MODE_DUAL) begin
                    sampleChan <= {2'h0, ~sampleChan[0]};
                end else begin
                    sampleChan <= sampleChan + 3'h1;
                end
            end else begin
                // idle: data never shows the last sample
                sampleIn <= ~sampleIn;
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/tb_appf_post_processing.sv
// self-checking bench for the adc post-processing stage
// assumes the source model drives the sample stream and the bench owns the register port
`timescale 1ns/1ps
`default_nettype none
module tb_appf_post_processing;
    logic sys_clk = 1'b0; // 100 MHz sample clock
    logic sys_rst = 1'b1; // async reset, high
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regRdData;
    logic [1:0] channelMode = 2'h0;
    logic overload = 1'b0;
    logic run = 1'b0; // source model on or off
    logic [11:0] sampleIn;
    logic [2:0] sampleChan;
    logic sampleValid;
    logic [11:0] sampleOut;
    logic [2:0] sampleOutChan;
    logic sampleOutValid;
    logic [11:0] hData [256]; // input history per cycle
    logic [2:0] hChan [256];
    logic hVal [256];
    logic [7:0] cyc = 8'h00; // cycle index into the history
    int error_cnt = 0;
    int total_checks = 0;

    appf_post_processing dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .channelMode(channelMode),
        .sampleIn(sampleIn), .sampleChan(sampleChan), .sampleValid(sampleValid), .overload(overload),
        .sampleOut(sampleOut), .sampleOutChan(sampleOutChan), .sampleOutValid(sampleOutValid));
    appf_adc_source src (.sys_clk(sys_clk), .sys_rst(sys_rst), .run(run), .channelMode(channelMode),
        .sampleIn(sampleIn), .sampleChan(sampleChan), .sampleValid(sampleValid));

    // clock
    always #5 sys_clk = ~sys_clk;
    // record what stands at the stream inputs in each cycle
    always @(posedge sys_clk) begin
        #1;
        cyc = cyc + 8'h01;
        hData[cyc] = sampleIn;
        hChan[cyc] = sampleChan;
        hVal[cyc] = sampleValid;
    end

    // compare one value and count it
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // one-cycle write strobe
    task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        regAddr <= addr;
        regWrData <= data;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    // one-cycle read strobe, data taken in the following cycle only
    task automatic reg_rd(input logic [7:0] addr, input logic [7:0] exp, input string what);
        @(posedge sys_clk);
        regAddr <= addr;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #2;
        chk(what, {24'h0, exp}, {24'h0, regRdData});
    endtask
    // program filters, routing, enables and channel mode
    task automatic setup(input logic [1:0] mode, input logic [7:0] en, input logic [7:0] fa,
                         input logic [7:0] fb, input logic [7:0] rec);
        reg_wr(appf_pkg::OFS_FILTER_A, fa);
        reg_wr(appf_pkg::OFS_FILTER_B, fb);
        reg_wr(appf_pkg::OFS_RECOVERY, rec);
        reg_wr(appf_pkg::OFS_ENABLES, en);
        @(posedge sys_clk);
        channelMode <= mode;
    endtask
    // flush, then compare output stream to the input stream lat cycles earlier
    // dmode: 0 timing only, 1 exact, 2 even exact and odd 11-bit, 3 all 11-bit
    task automatic stream_check(input int lat, input int dmode, input int n);
        logic [7:0] j;
        repeat (70) @(posedge sys_clk);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            #2;
            j = cyc - 8'(lat);
            chk("out valid", {31'h0, hVal[j]}, {31'h0, sampleOutValid});
            if (hVal[j] === 1'b1) begin
                chk("out channel", {29'h0, hChan[j]}, {29'h0, sampleOutChan});
                if (dmode == 1 || (dmode == 2 && hChan[j][0] === 1'b0)) begin
                    chk("out data", {20'h0, hData[j]}, {20'h0, sampleOut});
                end
                if (dmode == 3 || (dmode == 2 && hChan[j][0] === 1'b1)) begin
                    chk("out data lsb", 32'h0, {31'h0, sampleOut[0]});
                end
            end
        end
    endtask

    // register reset values, per-option enables, masking and unmapped places
    task automatic test_registers();
        reg_rd(appf_pkg::OFS_ENABLES, 8'h00, "enables reset");
        reg_rd(appf_pkg::OFS_FILTER_A, 8'h00, "filter a reset");
        reg_rd(appf_pkg::OFS_FILTER_B, 8'h00, "filter b reset");
        reg_rd(appf_pkg::OFS_RECOVERY, 8'h00, "recovery reset");
        reg_rd(appf_pkg::OFS_STATUS, 8'h00, "status reset");
        reg_wr(appf_pkg::OFS_ENABLES, 8'h1F);
        reg_rd(appf_pkg::OFS_ENABLES, 8'h1F, "enables all");
        reg_wr(appf_pkg::OFS_ENABLES, 8'h0A);
        reg_rd(appf_pkg::OFS_ENABLES, 8'h0A, "enables some");
        reg_wr(appf_pkg::OFS_RECOVERY, 8'hFF);
        reg_rd(appf_pkg::OFS_RECOVERY, 8'h07, "recovery bits");
        reg_wr(appf_pkg::OFS_FILTER_A, 8'hC5);
        reg_rd(appf_pkg::OFS_FILTER_A, 8'hC5, "filter a");
        reg_wr(8'h80, 8'hFF);
        reg_rd(8'h80, 8'h00, "unmapped read");
        $display("test registers done");
    endtask
    // requantizers off: data passes unchanged after two cycles
    task automatic test_bypass();
        setup(appf_pkg::MODE_SINGLE, 8'h00, 8'h00, 8'h00, 8'h00);
        reg_rd(appf_pkg::OFS_STATUS, 8'h00, "bypass status");
        stream_check(2, 1, 40);
        $display("test bypass done");
    endtask
    // delay recovery in dual, octal, single and dual without the dual enable
    task automatic test_recovery();
        setup(appf_pkg::MODE_DUAL, 8'h01, 8'h00, 8'h80, 8'h00);
        reg_rd(appf_pkg::OFS_STATUS, 8'h01, "dual recovery status");
        stream_check(60, 0, 40);
        setup(appf_pkg::MODE_DUAL, 8'h01, 8'h00, 8'h80, 8'h01);
        reg_rd(appf_pkg::OFS_STATUS, 8'h01, "second zone status");
        setup(appf_pkg::MODE_OCTAL, 8'h03, 8'h05, 8'h80, 8'h06);
        reg_rd(appf_pkg::OFS_STATUS, 8'h01, "octal recovery status");
        stream_check(60, 0, 40);
        setup(appf_pkg::MODE_SINGLE, 8'h01, 8'h00, 8'h80, 8'h00);
        reg_rd(appf_pkg::OFS_STATUS, 8'h00, "single recovery status");
        stream_check(2, 1, 40);
        setup(appf_pkg::MODE_DUAL, 8'h01, 8'h00, 8'h00, 8'h00);
        reg_rd(appf_pkg::OFS_STATUS, 8'h00, "no dual enable status");
        stream_check(2, 1, 40);
        $display("test recovery done");
    endtask
    // requantizers in single and dual modes, with an overload burst
    task automatic test_requantizer();
        setup(appf_pkg::MODE_SINGLE, 8'h0A, 8'h85, 8'h05, 8'h00);
        reg_rd(appf_pkg::OFS_STATUS, 8'h02, "single requantizer status");
        @(posedge sys_clk);
        overload <= 1'b1;
        repeat (3) @(posedge sys_clk);
        overload <= 1'b0;
        stream_check(2, 3, 40);
        setup(appf_pkg::MODE_SINGLE, 8'h04, 8'h2A, 8'h00, 8'h00);
        reg_rd(appf_pkg::OFS_STATUS, 8'h02, "twelve bit status");
        stream_check(2, 0, 40);
        setup(appf_pkg::MODE_DUAL, 8'h08, 8'h00, 8'h95, 8'h00);
        reg_rd(appf_pkg::OFS_STATUS, 8'h04, "dual requantizer status");
        stream_check(2, 2, 60);
        $display("test requantizer done");
    endtask

    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        run <= 1'b1;
        test_registers();
        test_bypass();
        test_recovery();
        test_requantizer();
        tally_and_finish();
    end
    // watchdog: the tests need about 1040 cycles
    initial begin
        #200000;
        error_cnt++;
        $display("wrong value watchdog expected done seen hang");
        tally_and_finish();
    end
endmodule
`default_nettype wire
